// ===== hdl/sdo_pkg.sv
// shared constants, types and helpers for the service-data link
package sdo_pkg;
  // identifier bases, node number added on top
  localparam logic [10:0] SDO_REQ_BASE = 11'h600;
  localparam logic [10:0] SDO_RSP_BASE = 11'h580;
  localparam int NODE_W = 7;
  // command bytes
  localparam logic [7:0] CMD_WR8 = 8'h2F;
  localparam logic [7:0] CMD_WR16 = 8'h2B;
  localparam logic [7:0] CMD_WR32 = 8'h23;
  localparam logic [7:0] CMD_RD = 8'h40;
  localparam logic [7:0] RSP_RD8 = 8'h4F;
  localparam logic [7:0] RSP_RD16 = 8'h4B;
  localparam logic [7:0] RSP_RD32 = 8'h43;
  localparam logic [7:0] RSP_WR = 8'h60;
  localparam logic [7:0] RSP_ABORT = 8'h80;
  // top three command bits of a segment request
  localparam logic [2:0] CMD_SEG_REQ = 3'h3;
  // abort codes
  localparam logic [31:0] AB_TOGGLE = 32'h05030000;
  localparam logic [31:0] AB_MEMORY = 32'h05040005;
  localparam logic [31:0] AB_UNSUPP = 32'h06010000;
  localparam logic [31:0] AB_WR_ONLY = 32'h06010001;
  localparam logic [31:0] AB_RD_ONLY = 32'h06010002;
  localparam logic [31:0] AB_NO_OBJ = 32'h06020000;
  localparam logic [31:0] AB_NO_MAP = 32'h06040041;
  localparam logic [31:0] AB_MAP_LEN = 32'h06040042;
  localparam logic [31:0] AB_PARAM = 32'h06040043;
  localparam logic [31:0] AB_OVERFLOW = 32'h06040047;
  localparam logic [31:0] AB_LEN_MISM = 32'h06070010;
  localparam logic [31:0] AB_LEN_LARGE = 32'h06070012;
  localparam logic [31:0] AB_LEN_SMALL = 32'h06070013;
  localparam logic [31:0] AB_RANGE = 32'h06090030;
  localparam logic [31:0] AB_TOO_HIGH = 32'h06090031;
  localparam logic [31:0] AB_TOO_LOW = 32'h06090032;
  localparam logic [31:0] AB_GENERAL = 32'h08000000;
  localparam logic [31:0] AB_NONE = 32'h00000000;
  // byte positions in the data field
  localparam int POS_CMD = 0;
  localparam int POS_IDX_LO = 1;
  localparam int POS_IDX_HI = 2;
  localparam int POS_SUB = 3;
  localparam int POS_VAL = 4;
  localparam logic [3:0] SDO_HDR_LEN = 4'h4;
  localparam logic [3:0] FRAME_MAX_LEN = 4'h8;
  localparam logic [3:0] ABORT_LEN = 4'h8;
  // cyclic transmit step
  localparam int PDO_STEP_NS = 100000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PDO_STEP_CYC = PDO_STEP_NS / CLK_PERIOD_NS;
  typedef logic [7:0][7:0] frame_data_t;
  typedef enum logic [1:0] {W8 = 2'h0, W16 = 2'h1, W32 = 2'h2} width_t;
  typedef enum logic [1:0] {ACC_RW = 2'h0, ACC_RO = 2'h1, ACC_WO = 2'h2}
    access_t;
  // value byte count of a width
  function automatic logic [3:0] width_bytes(input width_t w);
    return (w == W8) ? 4'h1 : (w == W16) ? 4'h2 : 4'h4;
  endfunction : width_bytes
  // write command byte of a width
  function automatic logic [7:0] wr_cmd(input width_t w);
    return (w == W8) ? CMD_WR8 : (w == W16) ? CMD_WR16 : CMD_WR32;
  endfunction : wr_cmd
  // width carried by a write command byte
  function automatic width_t cmd_width(input logic [7:0] c);
    return (c == CMD_WR8) ? W8 : (c == CMD_WR16) ? W16 : W32;
  endfunction : cmd_width
  // identifier of a service for a node
  function automatic logic [10:0] node_cob(input logic [10:0] base,
                                           input logic [NODE_W-1:0] node);
    return base + {4'h0, node};
  endfunction : node_cob
endpackage : sdo_pkg

// ===== hdl/sdo_link_if.sv
// frame-level link between host and device
`timescale 1ns/1ns
`default_nettype none
interface sdo_link_if;
  // host to device frame, one-cycle strobe
  logic h2d_valid;
  logic [10:0] h2d_id;
  logic [3:0] h2d_len;
  sdo_pkg::frame_data_t h2d_data;
  // device to host frame, one-cycle strobe
  logic d2h_valid;
  logic [10:0] d2h_id;
  logic [3:0] d2h_len;
  sdo_pkg::frame_data_t d2h_data;
  modport dev (input h2d_valid, h2d_id, h2d_len, h2d_data,
               output d2h_valid, d2h_id, d2h_len, d2h_data);
  modport host (output h2d_valid, h2d_id, h2d_len, h2d_data,
                input d2h_valid, d2h_id, d2h_len, d2h_data);
endinterface : sdo_link_if
`default_nettype wire

// ===== hdl/sdo_reply_pack.sv
// packs a service-data reply into length and data bytes
`timescale 1ns/1ns
`default_nettype none
module sdo_reply_pack (
  // reply content
  input wire logic is_abort_i,
  input wire logic is_wr_i,
  input wire sdo_pkg::width_t width_i,
  input wire logic [15:0] index_i,
  input wire logic [7:0] sub_i,
  input wire logic [31:0] value_i,
  // packed frame
  output logic [3:0] len_o,
  output sdo_pkg::frame_data_t data_o
);
  logic [3:0] nval; // value bytes carried

  // pure decode, the caller registers the result
  always_comb begin
    data_o = '0;
    if (is_abort_i) begin
      data_o[sdo_pkg::POS_CMD] = sdo_pkg::RSP_ABORT;
      nval = sdo_pkg::ABORT_LEN - sdo_pkg::SDO_HDR_LEN;
    end else if (is_wr_i) begin
      data_o[sdo_pkg::POS_CMD] = sdo_pkg::RSP_WR;
      nval = 4'h0;
    end else begin
      // read answer byte follows the object width
      data_o[sdo_pkg::POS_CMD] = (width_i == sdo_pkg::W8) ?
        sdo_pkg::RSP_RD8 : (width_i == sdo_pkg::W16) ?
        sdo_pkg::RSP_RD16 : sdo_pkg::RSP_RD32;
      nval = sdo_pkg::width_bytes(width_i);
    end
    // echo of index and subindex
    data_o[sdo_pkg::POS_IDX_LO] = index_i[7:0];
    data_o[sdo_pkg::POS_IDX_HI] = index_i[15:8];
    data_o[sdo_pkg::POS_SUB] = sub_i;
    // value or code, least significant byte first
    for (int k = 0; k < 4; k++) begin
      if (4'(k) < nval) begin
        data_o[sdo_pkg::POS_VAL + k] = value_i[8*k +: 8];
      end
    end
    len_o = sdo_pkg::SDO_HDR_LEN + nval;
  end
endmodule : sdo_reply_pack
`default_nettype wire

// ===== hdl/sdo_dev_end.sv
// device end: service-data interpreter and process-data engine
// Functional notes
// - requests 600h+node, replies 580h+node
// - write command byte encodes 8/16/32 width
// - read request command byte is 40h
// - read reply 4Fh/4Bh/43h by width
// - write acknowledge byte is always 60h
// - index low, index high, subindex, echoed
// - values little-endian, exactly 1/2/4 bytes
// - failures answer 80h plus 4-byte code
// - access type and direction fault codes
// - missing object gives 06020000h
// - mapping fault codes 06040041h/06040042h
// - length fault codes 06070010h/12h/13h
// - range fault codes 06090030h/31h/32h
// - toggle fault gives 05030000h
// - overflow, parameter, memory, general codes
// - host keeps one request outstanding
// - process data never acknowledged
// - transmit/evaluate process data on event
// - host accepts process data anytime
// - process data raw, up to 8 bytes
// - event and cyclic transmission supported
`timescale 1ns/1ns
`default_nettype none
module sdo_dev_end #(
  parameter int STEP_CYCLES = sdo_pkg::PDO_STEP_CYC // one 100 us step
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // link to the host
  sdo_link_if.dev link,
  // node number switches
  input wire logic [sdo_pkg::NODE_W-1:0] node_id_i,
  // object directory access
  output logic [15:0] app_index_o,
  output logic [7:0] app_sub_o,
  output logic app_wr_o,
  output sdo_pkg::width_t app_width_o,
  output logic [31:0] app_wdata_o,
  output logic app_req_o,
  input wire logic app_exists_i,
  input wire sdo_pkg::access_t app_access_i,
  input wire sdo_pkg::width_t app_width_i,
  input wire logic app_done_i,
  input wire logic [31:0] app_abort_i,
  input wire logic [31:0] app_rdata_i,
  output logic sdo_busy_o,
  // transmit process data
  input wire logic tpdo_en_i,
  input wire logic [10:0] tpdo_cob_i,
  input wire logic tpdo_cyclic_i,
  input wire logic [15:0] tpdo_period_i,
  input wire logic tpdo_evt_i,
  input wire logic [3:0] tpdo_len_i,
  input wire sdo_pkg::frame_data_t tpdo_data_i,
  // receive process data
  input wire logic rpdo_en_i,
  input wire logic [10:0] rpdo_cob_i,
  input wire logic rpdo_on_evt_i,
  input wire logic rpdo_evt_i,
  output logic rpdo_valid_o,
  output logic [3:0] rpdo_len_o,
  output sdo_pkg::frame_data_t rpdo_data_o
);
  // one-hot request sequencer
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_LOOK = 4'h2, ST_EXEC = 4'h4, ST_REPLY = 4'h8
  } dev_state_t;

  typedef struct packed {
    dev_state_t st;
    logic [sdo_pkg::NODE_W-1:0] node_s1; // first sync stage
    logic [sdo_pkg::NODE_W-1:0] node_s2; // synced node number
    logic is_wr;
    sdo_pkg::width_t width;
    logic [15:0] idx;
    logic [7:0] sub;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [31:0] abort; // zero while no fault
    logic app_req;
    logic tx_valid;
    logic [10:0] tx_id;
    logic [3:0] tx_len;
    sdo_pkg::frame_data_t tx_data;
    logic tpdo_pend;
    logic [15:0] step_cnt;
    logic [15:0] per_cnt;
    logic rpdo_have;
    logic [3:0] rpdo_blen;
    sdo_pkg::frame_data_t rpdo_buf;
    logic rpdo_valid;
    logic [3:0] rpdo_len;
    sdo_pkg::frame_data_t rpdo_data;
  } dev_reg_t;

  dev_reg_t q_ff; // all state
  dev_reg_t nxt_q; // next state
  logic sdo_hit; // request for this node
  logic rpdo_hit; // receive process frame
  logic [7:0] cmd; // incoming command byte
  logic [3:0] need; // expected write length
  logic [3:0] rep_len; // packed reply length
  sdo_pkg::frame_data_t rep_data; // packed reply bytes

  // reply bytes follow the stored request and outcome
  sdo_reply_pack u_pack (
    .is_abort_i(q_ff.abort != sdo_pkg::AB_NONE),
    .is_wr_i(q_ff.is_wr),
    .width_i(q_ff.width),
    .index_i(q_ff.idx),
    .sub_i(q_ff.sub),
    .value_i((q_ff.abort != sdo_pkg::AB_NONE) ? q_ff.abort : q_ff.rdata),
    .len_o(rep_len),
    .data_o(rep_data)
  );

  // next-state logic
  always_comb begin
    nxt_q = q_ff;
    nxt_q.node_s1 = node_id_i;
    nxt_q.node_s2 = q_ff.node_s1;
    nxt_q.tx_valid = 1'b0;
    nxt_q.app_req = 1'b0;
    nxt_q.rpdo_valid = 1'b0;
    cmd = link.h2d_data[sdo_pkg::POS_CMD];
    need = sdo_pkg::SDO_HDR_LEN +
      sdo_pkg::width_bytes(sdo_pkg::cmd_width(cmd));
    sdo_hit = link.h2d_valid && (link.h2d_id ==
      sdo_pkg::node_cob(sdo_pkg::SDO_REQ_BASE, q_ff.node_s2));
    rpdo_hit = link.h2d_valid && rpdo_en_i && !sdo_hit &&
      (link.h2d_id == rpdo_cob_i);
    unique case (q_ff.st)
      // requests while busy are dropped, host waits for the reply
      ST_IDLE: begin
        if (sdo_hit) begin
          nxt_q.idx = {link.h2d_data[sdo_pkg::POS_IDX_HI],
                       link.h2d_data[sdo_pkg::POS_IDX_LO]};
          nxt_q.sub = link.h2d_data[sdo_pkg::POS_SUB];
          nxt_q.wdata = {link.h2d_data[sdo_pkg::POS_VAL + 3],
                         link.h2d_data[sdo_pkg::POS_VAL + 2],
                         link.h2d_data[sdo_pkg::POS_VAL + 1],
                         link.h2d_data[sdo_pkg::POS_VAL]};
          nxt_q.rdata = '0;
          nxt_q.abort = sdo_pkg::AB_NONE;
          nxt_q.is_wr = 1'b0;
          if (cmd == sdo_pkg::CMD_RD) begin
            if (link.h2d_len < sdo_pkg::SDO_HDR_LEN) begin
              nxt_q.abort = sdo_pkg::AB_LEN_SMALL;
            end
          end else if (cmd == sdo_pkg::CMD_WR8 || cmd == sdo_pkg::CMD_WR16 ||
                       cmd == sdo_pkg::CMD_WR32) begin
            nxt_q.is_wr = 1'b1;
            nxt_q.width = sdo_pkg::cmd_width(cmd);
            if (link.h2d_len < need) begin
              nxt_q.abort = sdo_pkg::AB_LEN_SMALL;
            end else if (link.h2d_len > need) begin
              nxt_q.abort = sdo_pkg::AB_LEN_LARGE;
            end
          end else if (cmd[7:5] == sdo_pkg::CMD_SEG_REQ) begin
            // segment request with no transfer open: toggle out of step
            nxt_q.abort = sdo_pkg::AB_TOGGLE;
          end else begin
            nxt_q.abort = sdo_pkg::AB_UNSUPP;
          end
          nxt_q.st = (nxt_q.abort == sdo_pkg::AB_NONE) ? ST_LOOK : ST_REPLY;
        end
      end
      // object attributes answer the index presented this cycle
      ST_LOOK: begin
        nxt_q.st = ST_REPLY;
        if (!app_exists_i) begin
          nxt_q.abort = sdo_pkg::AB_NO_OBJ;
        end else if (!q_ff.is_wr && app_access_i == sdo_pkg::ACC_WO) begin
          nxt_q.abort = sdo_pkg::AB_WR_ONLY;
        end else if (q_ff.is_wr && app_access_i == sdo_pkg::ACC_RO) begin
          nxt_q.abort = sdo_pkg::AB_RD_ONLY;
        end else if (q_ff.is_wr && app_width_i != q_ff.width) begin
          nxt_q.abort = sdo_pkg::AB_LEN_MISM;
        end else begin
          nxt_q.width = app_width_i;
          nxt_q.app_req = 1'b1;
          nxt_q.st = ST_EXEC;
        end
      end
      // the directory reports range, mapping, memory and other faults
      ST_EXEC: begin
        if (app_done_i) begin
          if (app_abort_i != sdo_pkg::AB_NONE) begin
            nxt_q.abort = app_abort_i;
          end else if (!q_ff.is_wr) begin
            nxt_q.rdata = app_rdata_i;
          end
          nxt_q.st = ST_REPLY;
        end
      end
      // exactly one reply frame, link slot is ours this cycle
      ST_REPLY: begin
        nxt_q.tx_valid = 1'b1;
        nxt_q.tx_id = sdo_pkg::node_cob(sdo_pkg::SDO_RSP_BASE,
                                        q_ff.node_s2);
        nxt_q.tx_len = rep_len;
        nxt_q.tx_data = rep_data;
        nxt_q.st = ST_IDLE;
      end
      default: begin
        nxt_q.st = ST_IDLE;
      end
    endcase
    // pending transmit goes out when the reply is not using the slot
    if (q_ff.tpdo_pend && q_ff.st != ST_REPLY) begin
      nxt_q.tx_valid = 1'b1;
      nxt_q.tx_id = tpdo_cob_i;
      nxt_q.tx_len = (tpdo_len_i > sdo_pkg::FRAME_MAX_LEN) ?
        sdo_pkg::FRAME_MAX_LEN : tpdo_len_i;
      nxt_q.tx_data = tpdo_data_i;
      nxt_q.tpdo_pend = 1'b0;
    end
    // cyclic timer in 100 us steps
    if (tpdo_en_i && tpdo_cyclic_i && tpdo_period_i != 16'h0000) begin
      nxt_q.step_cnt = q_ff.step_cnt + 16'h0001;
      if (q_ff.step_cnt == 16'(STEP_CYCLES - 1)) begin
        nxt_q.step_cnt = 16'h0000;
        nxt_q.per_cnt = q_ff.per_cnt + 16'h0001;
        if (nxt_q.per_cnt >= tpdo_period_i) begin
          nxt_q.per_cnt = 16'h0000;
          nxt_q.tpdo_pend = 1'b1;
        end
      end
    end else begin
      nxt_q.step_cnt = 16'h0000;
      nxt_q.per_cnt = 16'h0000;
    end
    // event trigger, placed after the clear so a new event is kept
    if (tpdo_en_i && tpdo_evt_i) begin
      nxt_q.tpdo_pend = 1'b1;
    end
    // receive: evaluate on arrival or on the configured event
    if (rpdo_on_evt_i && rpdo_evt_i && q_ff.rpdo_have) begin
      nxt_q.rpdo_valid = 1'b1;
      nxt_q.rpdo_len = q_ff.rpdo_blen;
      nxt_q.rpdo_data = q_ff.rpdo_buf;
      nxt_q.rpdo_have = 1'b0;
    end
    if (rpdo_hit) begin
      // no answer frame is ever produced for this
      nxt_q.rpdo_buf = link.h2d_data;
      nxt_q.rpdo_blen = link.h2d_len;
      nxt_q.rpdo_have = rpdo_on_evt_i;
      if (!rpdo_on_evt_i) begin
        nxt_q.rpdo_valid = 1'b1;
        nxt_q.rpdo_len = link.h2d_len;
        nxt_q.rpdo_data = link.h2d_data;
      end
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_ff <= '0;
      q_ff.st <= ST_IDLE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // outputs straight from state
  assign link.d2h_valid = q_ff.tx_valid;
  assign link.d2h_id = q_ff.tx_id;
  assign link.d2h_len = q_ff.tx_len;
  assign link.d2h_data = q_ff.tx_data;
  assign app_index_o = q_ff.idx;
  assign app_sub_o = q_ff.sub;
  assign app_wr_o = q_ff.is_wr;
  assign app_width_o = q_ff.width;
  assign app_wdata_o = q_ff.wdata;
  assign app_req_o = q_ff.app_req;
  assign sdo_busy_o = (q_ff.st != ST_IDLE);
  assign rpdo_valid_o = q_ff.rpdo_valid;
  assign rpdo_len_o = q_ff.rpdo_len;
  assign rpdo_data_o = q_ff.rpdo_data;
endmodule : sdo_dev_end
`default_nettype wire

// ===== hdl/sdo_host_end.sv
// host end: issues service-data requests, collects replies and frames
`timescale 1ns/1ns
`default_nettype none
module sdo_host_end (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // link to the device
  sdo_link_if.host link,
  // addressed node
  input wire logic [sdo_pkg::NODE_W-1:0] node_id_i,
  // request port
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_write_i,
  input wire sdo_pkg::width_t cmd_width_i,
  input wire logic [15:0] cmd_index_i,
  input wire logic [7:0] cmd_sub_i,
  input wire logic [31:0] cmd_wdata_i,
  // reply port
  output logic rsp_valid_o,
  output logic rsp_abort_o,
  output logic [7:0] rsp_cmd_o,
  output logic [31:0] rsp_value_o,
  // process frames out to the device
  input wire logic pdo_send_i,
  output logic pdo_ready_o,
  input wire logic [10:0] pdo_id_i,
  input wire logic [3:0] pdo_len_i,
  input wire sdo_pkg::frame_data_t pdo_data_i,
  // process frames in from the device
  output logic pdo_valid_o,
  output logic [10:0] pdo_id_o,
  output logic [3:0] pdo_len_o,
  output sdo_pkg::frame_data_t pdo_data_o
);
  // one-hot request tracker
  typedef enum logic [1:0] {HS_IDLE = 2'h1, HS_WAIT = 2'h2} host_state_t;

  typedef struct packed {
    host_state_t st;
    logic [sdo_pkg::NODE_W-1:0] node_s1; // first sync stage
    logic [sdo_pkg::NODE_W-1:0] node_s2; // synced node number
    logic tx_valid;
    logic [10:0] tx_id;
    logic [3:0] tx_len;
    sdo_pkg::frame_data_t tx_data;
    logic rsp_valid;
    logic rsp_abort;
    logic [7:0] rsp_cmd;
    logic [31:0] rsp_value;
    logic pdo_valid;
    logic [10:0] pdo_id;
    logic [3:0] pdo_len;
    sdo_pkg::frame_data_t pdo_data;
  } host_reg_t;

  host_reg_t q_ff; // all state
  host_reg_t nxt_q; // next state
  logic take; // request accepted now
  logic rsp_hit; // reply for our node

  // only one request may be open at a time
  assign cmd_ready_o = (q_ff.st == HS_IDLE);
  assign take = cmd_valid_i && cmd_ready_o;
  // a request takes the frame slot before process data
  assign pdo_ready_o = !take;

  // next-state logic
  always_comb begin
    nxt_q = q_ff;
    nxt_q.node_s1 = node_id_i;
    nxt_q.node_s2 = q_ff.node_s1;
    nxt_q.tx_valid = 1'b0;
    nxt_q.rsp_valid = 1'b0;
    nxt_q.pdo_valid = 1'b0;
    rsp_hit = link.d2h_valid && (link.d2h_id ==
      sdo_pkg::node_cob(sdo_pkg::SDO_RSP_BASE, q_ff.node_s2));
    if (take) begin
      nxt_q.tx_valid = 1'b1;
      nxt_q.tx_id = sdo_pkg::node_cob(sdo_pkg::SDO_REQ_BASE,
                                      q_ff.node_s2);
      nxt_q.tx_data = '0;
      nxt_q.tx_data[sdo_pkg::POS_IDX_LO] = cmd_index_i[7:0];
      nxt_q.tx_data[sdo_pkg::POS_IDX_HI] = cmd_index_i[15:8];
      nxt_q.tx_data[sdo_pkg::POS_SUB] = cmd_sub_i;
      if (cmd_write_i) begin
        nxt_q.tx_data[sdo_pkg::POS_CMD] = sdo_pkg::wr_cmd(cmd_width_i);
        for (int k = 0; k < 4; k++) begin
          if (4'(k) < sdo_pkg::width_bytes(cmd_width_i)) begin
            nxt_q.tx_data[sdo_pkg::POS_VAL + k] = cmd_wdata_i[8*k +: 8];
          end
        end
        nxt_q.tx_len = sdo_pkg::SDO_HDR_LEN +
          sdo_pkg::width_bytes(cmd_width_i);
      end else begin
        nxt_q.tx_data[sdo_pkg::POS_CMD] = sdo_pkg::CMD_RD;
        nxt_q.tx_len = sdo_pkg::SDO_HDR_LEN;
      end
      nxt_q.st = HS_WAIT;
    end else if (pdo_send_i) begin
      // process data go out with no answer expected
      nxt_q.tx_valid = 1'b1;
      nxt_q.tx_id = pdo_id_i;
      nxt_q.tx_len = pdo_len_i;
      nxt_q.tx_data = pdo_data_i;
    end
    if (rsp_hit && q_ff.st == HS_WAIT) begin
      // value or abort code, lowest byte first, unused bytes are zero
      nxt_q.rsp_valid = 1'b1;
      nxt_q.rsp_cmd = link.d2h_data[sdo_pkg::POS_CMD];
      nxt_q.rsp_abort = (link.d2h_data[sdo_pkg::POS_CMD] ==
                         sdo_pkg::RSP_ABORT);
      for (int k = 0; k < 4; k++) begin
        nxt_q.rsp_value[8*k +: 8] = (4'(k) + sdo_pkg::SDO_HDR_LEN <
          link.d2h_len) ? link.d2h_data[sdo_pkg::POS_VAL + k] : 8'h00;
      end
      nxt_q.st = HS_IDLE;
    end else if (link.d2h_valid && !rsp_hit) begin
      // any other frame is taken at once, no flow control
      nxt_q.pdo_valid = 1'b1;
      nxt_q.pdo_id = link.d2h_id;
      nxt_q.pdo_len = link.d2h_len;
      nxt_q.pdo_data = link.d2h_data;
    end
  end

  // state register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_ff <= '0;
      q_ff.st <= HS_IDLE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // outputs straight from state
  assign link.h2d_valid = q_ff.tx_valid;
  assign link.h2d_id = q_ff.tx_id;
  assign link.h2d_len = q_ff.tx_len;
  assign link.h2d_data = q_ff.tx_data;
  assign rsp_valid_o = q_ff.rsp_valid;
  assign rsp_abort_o = q_ff.rsp_abort;
  assign rsp_cmd_o = q_ff.rsp_cmd;
  assign rsp_value_o = q_ff.rsp_value;
  assign pdo_valid_o = q_ff.pdo_valid;
  assign pdo_id_o = q_ff.pdo_id;
  assign pdo_len_o = q_ff.pdo_len;
  assign pdo_data_o = q_ff.pdo_data;
endmodule : sdo_host_end
`default_nettype wire

// ===== testbench/can_sdo_pdo_server_props.sv
// link assertions
`timescale 1ns/1ns
`default_nettype none
module can_sdo_pdo_server_props #(
  parameter logic [6:0] NODE = 7'h00
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // link signals
  input wire logic h2d_valid,
  input wire logic [10:0] h2d_id,
  input wire logic [3:0] h2d_len,
  input wire sdo_pkg::frame_data_t h2d_data,
  input wire logic d2h_valid,
  input wire logic [10:0] d2h_id,
  input wire logic [3:0] d2h_len,
  input wire sdo_pkg::frame_data_t d2h_data
);
  localparam logic [10:0] RQ = 11'h600 + {4'h0, NODE};
  localparam logic [10:0] RS = 11'h580 + {4'h0, NODE};
  wire req = h2d_valid && h2d_id == RQ; // request to this node
  wire rsp = d2h_valid && d2h_id == RS; // reply from this node
  logic open_ff; // one request outstanding
  logic [31:0] rq_ff; // open request header
  // track the open request; busy ones dropped
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      open_ff <= 1'b0;
      rq_ff <= 32'h00000000;
    end else if (req && !open_ff) begin
      open_ff <= 1'b1;
      rq_ff <= h2d_data[3:0];
    end else if (rsp) begin
      open_ff <= 1'b0;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  reply_id_a: assert property (d2h_valid && d2h_id[10:7] == 4'hB |->
    d2h_id == RS) else $error("reply id wrong");
  reply_echo_a: assert property (rsp |-> d2h_data[3:1] == rq_ff[31:8])
    else $error("no echo");
  abort_len_a: assert property (rsp && d2h_data[0] == 8'h80 |->
    d2h_len == 4'h8) else $error("abort len");
  ack_len_a: assert property (rsp && d2h_data[0] == 8'h60 |->
    d2h_len == 4'h4) else $error("ack len");
  read_len_a: assert property (rsp && rq_ff[7:0] == 8'h40 &&
    d2h_data[0] != 8'h80 |-> d2h_data[0] inside {8'h4F, 8'h4B, 8'h43} &&
    d2h_len == (d2h_data[0] == 8'h4F ? 4'h5 : d2h_data[0] == 8'h4B ? 4'h6
    : 4'h8)) else $error("bad read");
  write_code_a: assert property (rsp && rq_ff[7:0] != 8'h40 |->
    d2h_data[0] inside {8'h60, 8'h80}) else $error("write reply bad");
  one_reply_a: assert property (rsp |-> open_ff)
    else $error("stray reply");
  reply_bound_a: assert property (req && !open_ff |-> ##[2:40] rsp)
    else $error("no reply");
  pdo_noack_a: assert property (h2d_valid && h2d_id != RQ && !open_ff
    |=> !d2h_valid [*4]) else $error("pdo answered");
endmodule : can_sdo_pdo_server_props
`default_nettype wire

// ===== testbench/can_sdo_pdo_server_tb_top.sv
// bench for host and device ends
`timescale 1ns/1ns
`default_nettype none
module can_sdo_pdo_server_tb_top;
  localparam logic [6:0] NODE = 7'h05;
  localparam logic [10:0] TCOB = 11'h185;
  localparam logic [10:0] RCOB = 11'h205;
  localparam sdo_pkg::width_t WT[3] =
    '{sdo_pkg::W8, sdo_pkg::W16, sdo_pkg::W32};
  localparam logic [7:0] RCT[3] = '{8'h4F, 8'h4B, 8'h43};
  localparam logic [31:0] MK[3] = '{32'h000000FF, 32'h0000FFFF, 32'hFFFFFFFF};
  localparam logic [31:0] AC[9] = '{32'h06040041, 32'h06040042, 32'h06090030,
    32'h06090031, 32'h06090032, 32'h06040047, 32'h06040043, 32'h05040005,
    32'h08000000};
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, cv = 1'b0, cw = 1'b0, ex = 1'b1;
  logic dn = 1'b0, tev = 1'b0, ps = 1'b0, en = 1'b1, off = 1'b0;
  sdo_pkg::width_t cwd = sdo_pkg::W8, awd = sdo_pkg::W8;
  sdo_pkg::access_t acc = sdo_pkg::ACC_RW;
  logic [31:0] wd = 32'hA1B2C3D4, ab = 32'h00000000, rd = 32'h12345678;
  sdo_pkg::frame_data_t tdat = 64'h8877665544332211;
  logic arq, rv, pv, rpv;
  logic [7:0] rc;
  logic [31:0] rval, aw;
  logic [10:0] pid;
  sdo_pkg::frame_data_t pdat, rpd;
  int n_errors = 0, tests_run = 0, cyc = 0;
  always #5 clk_sys_i = ~clk_sys_i;
  sdo_link_if u_sdo_link_if ();
  sdo_dev_end #(.STEP_CYCLES(4)) u_sdo_dev_end (.clk_sys_i, .rst_n_i,
    .link(u_sdo_link_if.dev), .node_id_i(NODE), .app_index_o(), .app_sub_o(),
    .app_wr_o(), .app_width_o(), .app_wdata_o(aw), .app_req_o(arq),
    .app_exists_i(ex), .app_access_i(acc), .app_width_i(awd), .app_done_i(dn),
    .app_abort_i(ab), .app_rdata_i(rd), .sdo_busy_o(), .tpdo_en_i(en),
    .tpdo_cob_i(TCOB), .tpdo_cyclic_i(off), .tpdo_period_i({15'h0, off}),
    .tpdo_evt_i(tev), .tpdo_len_i(4'h8), .tpdo_data_i(tdat), .rpdo_en_i(en),
    .rpdo_cob_i(RCOB), .rpdo_on_evt_i(off), .rpdo_evt_i(off),
    .rpdo_valid_o(rpv), .rpdo_len_o(), .rpdo_data_o(rpd));
  sdo_host_end u_sdo_host_end (.clk_sys_i, .rst_n_i,
    .link(u_sdo_link_if.host), .node_id_i(NODE), .cmd_valid_i(cv),
    .cmd_ready_o(), .cmd_write_i(cw), .cmd_width_i(cwd),
    .cmd_index_i(16'h6093), .cmd_sub_i(8'h01), .cmd_wdata_i(wd),
    .rsp_valid_o(rv), .rsp_abort_o(), .rsp_cmd_o(rc), .rsp_value_o(rval),
    .pdo_send_i(ps), .pdo_ready_o(), .pdo_id_i(RCOB), .pdo_len_i(4'h8),
    .pdo_data_i(tdat), .pdo_valid_o(pv), .pdo_id_o(pid), .pdo_len_o(),
    .pdo_data_o(pdat));
  can_sdo_pdo_server_props #(.NODE(NODE)) u_can_sdo_pdo_server_props (
    .clk_sys_i, .rst_n_i, .h2d_valid(u_sdo_link_if.h2d_valid),
    .h2d_id(u_sdo_link_if.h2d_id), .h2d_len(u_sdo_link_if.h2d_len),
    .h2d_data(u_sdo_link_if.h2d_data), .d2h_valid(u_sdo_link_if.d2h_valid),
    .d2h_id(u_sdo_link_if.d2h_id), .d2h_len(u_sdo_link_if.d2h_len),
    .d2h_data(u_sdo_link_if.d2h_data));
  // directory answers a cycle later; hang bound
  always @(posedge clk_sys_i) begin
    dn <= arq;
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      give_verdict();
    end
  end
  // closing verdict
  task automatic give_verdict();
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict
  // counted comparison
  task automatic chk(input string nm, input logic [63:0] e,
    input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one request with directory attributes
  task automatic sdo(input logic w, input sdo_pkg::width_t cw_,
    input sdo_pkg::width_t ow, input sdo_pkg::access_t a, input logic e,
    input logic [31:0] abc, input logic [7:0] ec, input logic [31:0] ev);
    @(posedge clk_sys_i);
    cv <= 1'b1; cw <= w; cwd <= cw_; awd <= ow; acc <= a; ex <= e; ab <= abc;
    @(posedge clk_sys_i);
    cv <= 1'b0;
    for (int i = 0; i < 60 && rv !== 1'b1; i++) begin
      @(posedge clk_sys_i); #1;
    end
    chk("reply cmd", {56'h0, ec}, {56'h0, rc});
    chk("reply value", {32'h0, ev}, {32'h0, rval});
  endtask : sdo
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    for (int k = 0; k < 3; k++) begin
      sdo(0, WT[k], WT[k], sdo_pkg::ACC_RW, 1, 0, RCT[k],
        rd & MK[k]);
      sdo(1, WT[k], WT[k], sdo_pkg::ACC_RW, 1, 0, 8'h60, 0);
      chk("write data", {32'h0, wd & MK[k]}, {32'h0, aw});
    end
    sdo(1, WT[2], WT[2], sdo_pkg::ACC_RO, 1, 0, 8'h80, 32'h06010002);
    sdo(0, WT[2], WT[2], sdo_pkg::ACC_WO, 1, 0, 8'h80, 32'h06010001);
    sdo(0, WT[2], WT[2], sdo_pkg::ACC_RW, 0, 0, 8'h80, 32'h06020000);
    sdo(1, WT[1], WT[2], sdo_pkg::ACC_RW, 1, 0, 8'h80, 32'h06070010);
    for (int k = 0; k < 9; k++)
      sdo(1, WT[2], WT[2], sdo_pkg::ACC_RW, 1, AC[k], 8'h80,
        AC[k]);
    @(posedge clk_sys_i);
    tev <= 1'b1;
    @(posedge clk_sys_i);
    tev <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1 chk("tx strobe", 1, pv);
    chk("tx frame id", {53'h0, TCOB}, {53'h0, pid});
    chk("tx frame data", tdat, pdat);
    @(posedge clk_sys_i);
    off <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    #1 chk("cyclic tx", 1, pv);
    @(posedge clk_sys_i);
    off <= 1'b0;
    @(posedge clk_sys_i);
    ps <= 1'b1;
    @(posedge clk_sys_i);
    ps <= 1'b0;
    @(posedge clk_sys_i);
    #1 chk("rx strobe", 1, rpv);
    chk("rx frame data", tdat, rpd);
    give_verdict();
  end
endmodule : can_sdo_pdo_server_tb_top
`default_nettype wire
